// ==== design/csie_pkg.sv ====
// Constants and types shared by the compare-and-skip executor.
// Assumes a core that runs four clock phases per instruction cycle.
package csie_pkg;

	// ----------------------------------------------------------------
	// Instruction word fields
	// ----------------------------------------------------------------
	localparam int unsigned OPC_MSB   = 15;
	localparam int unsigned OPC_LSB   = 9;
	localparam int unsigned ACC_BIT   = 8;
	localparam int unsigned FADDR_MSB = 7;

	// Opcode field values, bits 15..9
	localparam logic [6:0] OPC_LESS    = 7'h30;
	localparam logic [6:0] OPC_EQUAL   = 7'h31;
	localparam logic [6:0] OPC_GREATER = 7'h32;

	// ----------------------------------------------------------------
	// Access bank mapping
	// ----------------------------------------------------------------
	localparam logic [7:0] ACCESS_SPLIT     = 8'h80;
	localparam logic [3:0] ACCESS_LOW_BANK  = 4'h0;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
	localparam int unsigned BANK_WIDTH      = 4;

	// ----------------------------------------------------------------
	// Phase, cycle state and operation types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		PH_Q1 = 4'b0001,
		PH_Q2 = 4'b0010,
		PH_Q3 = 4'b0100,
		PH_Q4 = 4'b1000
	} csie_phase_type;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_CMP    = 4'b0010,
		ST_SKIP_A = 4'b0100,
		ST_SKIP_B = 4'b1000
	} csie_state_type;

	typedef enum logic [2:0] {
		OP_NONE    = 3'b000,
		OP_LESS    = 3'b001,
		OP_EQUAL   = 3'b010,
		OP_GREATER = 3'b100
	} csie_op_type;

	// Reset values
	localparam csie_phase_type PHASE_RST = PH_Q1;
	localparam csie_state_type STATE_RST = ST_IDLE;

endpackage

// ==== design/csie_compare.sv ====
// Unsigned compare of a file operand against the working register.
// Assumes both operands are stable during the processing phase.
`timescale 1ns/1ns

module csie_compare (
	input  wire logic [7:0] file_val_i,
	input  wire logic [7:0] working_register_i,
	output logic            greater_o,
	output logic            less_o,
	output logic            equal_o
);

	logic [8:0] diff;

	// ------------------------------------------------------------
	// Subtract working register from file operand
	// ------------------------------------------------------------
	// Borrow out of the 9-bit difference marks file < working register
	assign diff      = {1'b0, file_val_i} - {1'b0, working_register_i}; // [RQ5]
	assign less_o    = diff[8];
	assign equal_o   = (diff == 9'h000);
	assign greater_o = !diff[8] && (diff != 9'h000);

endmodule // csie_compare

// ==== design/csie_compare_skip_exec.sv ====
// Decoder and executor for the three compare-and-skip instructions.
// Assumes fetch presents the instruction word in Q1, the data memory
// answers a Q2 read by the following clock edge, and fetch reports in
// Q4 whether the already fetched next instruction is two words long.
`timescale 1ns/1ns

// What this block does
// [RQ1] Opcode 0110 010a ffff ffff decodes as compare, skip if greater.
// [RQ2] Opcode 0110 000a ffff ffff decodes as compare, skip if less.
// [RQ3] Greater variant skips only when file byte strictly exceeds working register.
// [RQ4] Less variant skips only when file byte is strictly below working register.
// [RQ5] Compare by unsigned subtraction; no result or flag is written back.
// [RQ6] A true skip discards the fetched word and runs one idle cycle.
// [RQ7] One program word; one cycle without skip, two cycles with skip.
// [RQ8] Skipping a two-word instruction inserts two idle cycles, three total.
// [RQ9] Access bit 0 uses the access bank; bit 1 uses the bank select register.
// [RQ10] Equal variant skips when file byte equals the working register.
// [RQ11] Q1 decode, Q2 read, Q3 process, Q4 no write; skip cycles do nothing.
module csie_compare_skip_exec #(
	parameter int unsigned BANK_W = csie_pkg::BANK_WIDTH
) (
	input  wire logic                  mclk_i,
	input  wire logic                  sys_rst_i,
	input  wire logic                  instr_valid_i,
	input  wire logic [15:0]           instr_word_i,
	input  wire logic [7:0]            working_register_i,
	input  wire logic [BANK_W-1:0]     bank_select_register_i,
	input  wire logic [7:0]            file_rdata_i,
	input  wire logic                  next_two_word_i,
	output csie_pkg::csie_phase_type   phase_o,
	output logic [BANK_W+7:0]          file_addr_o,
	output logic                       file_rd_o,
	output logic                       file_wr_o,
	output logic                       instr_accept_o,
	output logic                       skip_o,
	output logic                       discard_o,
	output logic                       done_o
);
	import csie_pkg::*;

	csie_phase_type    phase_q, phase_d;
	csie_state_type    state_q, state_d;
	csie_op_type       op_q, op_d;
	logic              acc_q, acc_d;
	logic [7:0]        faddr_q, faddr_d;
	logic [BANK_W+7:0] addr_q, addr_d;
	logic [7:0]        work_q, work_d;
	logic              skip_q, skip_d;
	logic              cmp_gt, cmp_lt, cmp_eq;
	csie_op_type       dec_op;

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------
	// Opcode field to operation; anything else is not ours
	function automatic csie_op_type decode_op(input logic [15:0] word);
		case (word[OPC_MSB:OPC_LSB])
			OPC_GREATER: decode_op = OP_GREATER; // [RQ1]
			OPC_LESS:    decode_op = OP_LESS;    // [RQ2]
			OPC_EQUAL:   decode_op = OP_EQUAL;   // [RQ10]
			default:     decode_op = OP_NONE;
		endcase
	endfunction

	// Full data address; the access bank overrides the bank register
	function automatic logic [BANK_W+7:0] bank_addr(input logic acc, input logic [7:0] f,
			input logic [BANK_W-1:0] bank_sel);
		logic [BANK_W-1:0] bank;
		bank = bank_sel;
		if (!acc) begin
			bank = (f >= ACCESS_SPLIT) ? BANK_W'(ACCESS_HIGH_BANK)
			                           : BANK_W'(ACCESS_LOW_BANK); // [RQ9]
		end
		bank_addr = {bank, f};
	endfunction

	assign dec_op = decode_op(instr_word_i);

	// ------------------------------------------------------------
	// Comparator
	// ------------------------------------------------------------
	csie_compare i_csie_compare (
		.file_val_i         (file_rdata_i),
		.working_register_i (work_q),
		.greater_o          (cmp_gt),
		.less_o             (cmp_lt),
		.equal_o            (cmp_eq)
	);

	// ------------------------------------------------------------
	// Phase sequencer
	// ------------------------------------------------------------
	// Four clocks make one instruction cycle
	always_comb begin
		case (phase_q)
			PH_Q1:   phase_d = PH_Q2;
			PH_Q2:   phase_d = PH_Q3;
			PH_Q3:   phase_d = PH_Q4;
			PH_Q4:   phase_d = PH_Q1;
			default: phase_d = PHASE_RST;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			phase_q <= PHASE_RST;
		end else begin
			phase_q <= phase_d;
		end
	end

	// ------------------------------------------------------------
	// Instruction cycle control
	// ------------------------------------------------------------
	// Next-value logic; a word offered during skip cycles is ignored,
	// since it is the one being thrown away
	always_comb begin
		state_d = state_q;
		op_d    = op_q;
		acc_d   = acc_q;
		faddr_d = faddr_q;
		addr_d  = addr_q;
		work_d  = work_q;
		skip_d  = skip_q;
		case (phase_q)
			PH_Q1: begin
				// Decode
				if (state_q == ST_IDLE && instr_valid_i && dec_op != OP_NONE) begin // [RQ11]
					state_d = ST_CMP;
					op_d    = dec_op;
					acc_d   = instr_word_i[ACC_BIT];
					faddr_d = instr_word_i[FADDR_MSB:0];
					addr_d  = bank_addr(instr_word_i[ACC_BIT], instr_word_i[FADDR_MSB:0],
						bank_select_register_i); // [RQ9]
					skip_d  = 1'b0;
				end
			end
			PH_Q2: begin
				// Read register f; working register taken alongside
				if (state_q == ST_CMP) begin
					work_d = working_register_i;
				end
			end
			PH_Q3: begin
				// Process data
				if (state_q == ST_CMP) begin
					case (op_q)
						OP_GREATER: skip_d = cmp_gt; // [RQ3]
						OP_LESS:    skip_d = cmp_lt; // [RQ4]
						OP_EQUAL:   skip_d = cmp_eq; // [RQ10]
						default:    skip_d = 1'b0;
					endcase
				end
			end
			PH_Q4: begin
				// No write; choose the next cycle kind
				case (state_q)
					ST_CMP: begin
						if (skip_q) begin
							state_d = next_two_word_i ? ST_SKIP_A : ST_SKIP_B; // [RQ6] [RQ8]
						end else begin
							state_d = ST_IDLE; // [RQ7]
						end
					end
					ST_SKIP_A: state_d = ST_SKIP_B; // [RQ8]
					ST_SKIP_B: state_d = ST_IDLE;   // [RQ6]
					default:   state_d = ST_IDLE;
				endcase
			end
			default: state_d = STATE_RST;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			state_q <= STATE_RST;
			op_q    <= OP_NONE;
			acc_q   <= 1'b0;
			faddr_q <= 8'h00;
			addr_q  <= '0;
			work_q  <= 8'h00;
			skip_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			op_q    <= op_d;
			acc_q   <= acc_d;
			faddr_q <= faddr_d;
			addr_q  <= addr_d;
			work_q  <= work_d;
			skip_q  <= skip_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Compare never writes memory or flags, so the write strobe is idle
	assign phase_o        = phase_q;
	assign file_addr_o    = addr_q;
	assign file_rd_o      = (phase_q == PH_Q2) && (state_q == ST_CMP); // [RQ11]
	assign file_wr_o      = 1'b0;                                      // [RQ5]
	assign instr_accept_o = (phase_q == PH_Q1) && (state_q == ST_IDLE)
	                        && instr_valid_i && (dec_op != OP_NONE);
	assign skip_o         = skip_q;
	assign discard_o      = (state_q == ST_SKIP_A) || (state_q == ST_SKIP_B); // [RQ6]
	assign done_o         = (phase_q == PH_Q4)
	                        && ((state_q == ST_CMP && !skip_q) || state_q == ST_SKIP_B); // [RQ7]

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_take(logic [6:0] opc);
		phase_q == PH_Q1 && state_q == ST_IDLE && instr_valid_i
			&& instr_word_i[OPC_MSB:OPC_LSB] == opc;
	endsequence
	sequence s_skip_end(logic two);
		phase_q == PH_Q4 && state_q == ST_CMP && skip_q && next_two_word_i == two;
	endsequence

	decode_greater_a: assert property ( // [RQ1]
		s_take(OPC_GREATER) |=> state_q == ST_CMP && op_q == OP_GREATER)
		else $error("greater compare not decoded");
	decode_less_a: assert property ( // [RQ2]
		s_take(OPC_LESS) |=> state_q == ST_CMP && op_q == OP_LESS)
		else $error("less compare not decoded");
	greater_skip_a: assert property ( // [RQ3]
		(phase_q == PH_Q3 && state_q == ST_CMP && op_q == OP_GREATER)
			|=> skip_q == ($past(file_rdata_i) > work_q))
		else $error("greater skip decision wrong");
	less_skip_a: assert property ( // [RQ4]
		(phase_q == PH_Q3 && state_q == ST_CMP && op_q == OP_LESS)
			|=> skip_q == ($past(file_rdata_i) < work_q))
		else $error("less skip decision wrong");
	equal_skip_a: assert property ( // [RQ10]
		(phase_q == PH_Q3 && state_q == ST_CMP && op_q == OP_EQUAL)
			|=> skip_q == ($past(file_rdata_i) == work_q))
		else $error("equal skip decision wrong");
	no_write_a: assert property ( // [RQ5]
		state_q == ST_CMP |-> !file_wr_o)
		else $error("compare wrote memory");
	single_nop_a: assert property ( // [RQ6]
		s_skip_end(1'b0) |=> discard_o [*4] ##1 state_q == ST_IDLE)
		else $error("single skip cycle wrong");
	no_skip_done_a: assert property ( // [RQ7]
		(phase_q == PH_Q4 && state_q == ST_CMP && !skip_q) |-> done_o ##1 state_q == ST_IDLE)
		else $error("one-cycle compare not done");
	double_nop_a: assert property ( // [RQ8]
		s_skip_end(1'b1) |=> state_q == ST_SKIP_A [*4] ##1 state_q == ST_SKIP_B [*4]
			##1 state_q == ST_IDLE)
		else $error("two-word skip wrong");
	access_bank_a: assert property ( // [RQ9]
		(phase_q == PH_Q2 && state_q == ST_CMP) |-> file_addr_o[7:0] == faddr_q
			&& (acc_q || file_addr_o[BANK_W+7:8] == ((faddr_q >= ACCESS_SPLIT)
			? BANK_W'(ACCESS_HIGH_BANK) : BANK_W'(ACCESS_LOW_BANK))))
		else $error("access bank address wrong");
	bank_reg_a: assert property ( // [RQ9]
		(instr_accept_o && instr_word_i[ACC_BIT])
			|=> file_addr_o[BANK_W+7:8] == $past(bank_select_register_i))
		else $error("bank register not used");
	read_phase_a: assert property ( // [RQ11]
		file_rd_o |-> phase_q == PH_Q2 && !discard_o)
		else $error("file read outside Q2");

endmodule // csie_compare_skip_exec

// ==== dv/tb_compare_skip_instr_exec.sv ====
// Self-checking bench for the compare-and-skip executor.
// Assumes the design holds its own assertions and a core with four phases per cycle.
`timescale 1ns/1ns

module tb_compare_skip_instr_exec;
	import csie_pkg::*;

	// ----------------------------------------------------------------
	// Signals and design instance
	// ----------------------------------------------------------------
	logic           mclk_i                 = 1'b0;
	logic           sys_rst_i              = 1'b1;
	logic           instr_valid_i          = 1'b0;
	logic [15:0]    instr_word_i           = 16'h0000;
	logic [7:0]     working_register_i     = 8'h00;
	logic [3:0]     bank_select_register_i = 4'h0;
	logic [7:0]     file_rdata_i           = 8'h00;
	logic           next_two_word_i        = 1'b0;
	csie_phase_type phase_o;
	logic [11:0]    file_addr_o;
	logic           file_rd_o;
	logic           file_wr_o;
	logic           instr_accept_o;
	logic           skip_o;
	logic           discard_o;
	logic           done_o;
	logic [3:0]     bank_sel               = 4'h0;
	int             mismatches             = 0;
	int             num_checks             = 0;

	csie_compare_skip_exec i_csie_compare_skip_exec (
		.mclk_i                 (mclk_i),
		.sys_rst_i              (sys_rst_i),
		.instr_valid_i          (instr_valid_i),
		.instr_word_i           (instr_word_i),
		.working_register_i     (working_register_i),
		.bank_select_register_i (bank_select_register_i),
		.file_rdata_i           (file_rdata_i),
		.next_two_word_i        (next_two_word_i),
		.phase_o                (phase_o),
		.file_addr_o            (file_addr_o),
		.file_rd_o              (file_rd_o),
		.file_wr_o              (file_wr_o),
		.instr_accept_o         (instr_accept_o),
		.skip_o                 (skip_o),
		.discard_o              (discard_o),
		.done_o                 (done_o)
	);

	// 100 MHz clock
	always #5 mclk_i = ~mclk_i;

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// One compare instruction; outputs are read at the edge that ends each phase,
	// so they still show the values of the phase just finished
	task automatic run_cmp(input logic [6:0] opc, input logic acc, input logic [7:0] f,
			input logic [7:0] w, input logic [7:0] fv, input logic two, input logic poke);
		logic        exp_skip;
		logic [11:0] exp_addr;
		int          n_clk;
		int          n_disc;
		int          n_bad;
		exp_skip = (opc == OPC_GREATER) ? (fv > w) : (opc == OPC_LESS) ? (fv < w) : (fv == w);
		exp_addr = acc ? {bank_sel, f}
		               : {(f >= ACCESS_SPLIT) ? ACCESS_HIGH_BANK : ACCESS_LOW_BANK, f};
		while (phase_o !== PH_Q4) @(posedge mclk_i);
		instr_valid_i          <= 1'b1;
		instr_word_i           <= {opc, acc, f};
		working_register_i     <= w;
		bank_select_register_i <= bank_sel;
		next_two_word_i        <= two;
		@(posedge mclk_i);
		check(instr_accept_o, 1'b1);
		instr_valid_i <= 1'b0;
		@(posedge mclk_i);
		check(file_rd_o, 1'b1);
		check(file_addr_o, exp_addr);
		file_rdata_i <= fv;
		@(posedge mclk_i);
		file_rdata_i <= ~fv;
		@(posedge mclk_i);
		check(skip_o, exp_skip);
		check(file_wr_o, 1'b0);
		check(done_o, !exp_skip);
		// Offer a word during the idle cycles; it must never be taken
		if (poke && exp_skip)
			instr_valid_i <= 1'b1;
		n_clk  = 0;
		n_disc = 0;
		n_bad  = 0;
		while (exp_skip && done_o !== 1'b1 && n_clk < 12) begin
			@(posedge mclk_i);
			n_clk++;
			if (discard_o === 1'b1)
				n_disc++;
			if (file_rd_o !== 1'b0 || file_wr_o !== 1'b0 || instr_accept_o !== 1'b0)
				n_bad++;
		end
		if (poke && exp_skip)
			instr_valid_i <= 1'b0;
		check(16'(n_clk), exp_skip ? (two ? 16'h0008 : 16'h0004) : 16'h0000);
		check(16'(n_disc), 16'(n_clk));
		check(16'(n_bad), 16'h0000);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Strictly greater, equal and less, with the unsigned boundary at 0x80
	task automatic t_greater();
		bank_sel = 4'h3;
		run_cmp(OPC_GREATER, 1'b1, 8'h21, 8'h40, 8'h41, 1'b0, 1'b0);
		run_cmp(OPC_GREATER, 1'b1, 8'h21, 8'h40, 8'h40, 1'b0, 1'b0);
		run_cmp(OPC_GREATER, 1'b1, 8'h21, 8'h40, 8'h3F, 1'b0, 1'b0);
		run_cmp(OPC_GREATER, 1'b1, 8'h22, 8'hFE, 8'hFF, 1'b0, 1'b0);
		run_cmp(OPC_GREATER, 1'b1, 8'h22, 8'h80, 8'h7F, 1'b0, 1'b0);
	endtask

	// Signed reading would flip the 0x7F against 0x80 case
	task automatic t_less();
		bank_sel = 4'h5;
		run_cmp(OPC_LESS, 1'b1, 8'h10, 8'h40, 8'h3F, 1'b0, 1'b0);
		run_cmp(OPC_LESS, 1'b1, 8'h10, 8'h40, 8'h40, 1'b0, 1'b0);
		run_cmp(OPC_LESS, 1'b1, 8'h10, 8'h40, 8'h41, 1'b0, 1'b0);
		run_cmp(OPC_LESS, 1'b1, 8'h11, 8'h80, 8'h7F, 1'b0, 1'b0);
		run_cmp(OPC_LESS, 1'b1, 8'h11, 8'h00, 8'hFF, 1'b0, 1'b0);
	endtask

	task automatic t_equal();
		bank_sel = 4'h6;
		run_cmp(OPC_EQUAL, 1'b1, 8'h33, 8'hA5, 8'hA5, 1'b0, 1'b0);
		run_cmp(OPC_EQUAL, 1'b1, 8'h33, 8'hA5, 8'hA4, 1'b0, 1'b0);
	endtask

	// Access bank override on both sides of the split, then the bank select path
	task automatic t_bank();
		bank_sel = 4'hA;
		run_cmp(OPC_LESS, 1'b0, 8'h7F, 8'h10, 8'h20, 1'b0, 1'b0);
		run_cmp(OPC_LESS, 1'b0, 8'h80, 8'h10, 8'h20, 1'b0, 1'b0);
		run_cmp(OPC_LESS, 1'b1, 8'h80, 8'h10, 8'h20, 1'b0, 1'b0);
	endtask

	// Two-word follower: three cycles on skip, still one cycle without
	task automatic t_two_word();
		bank_sel = 4'h1;
		run_cmp(OPC_GREATER, 1'b1, 8'h05, 8'h01, 8'h02, 1'b1, 1'b0);
		run_cmp(OPC_GREATER, 1'b1, 8'h05, 8'h02, 8'h01, 1'b1, 1'b0);
	endtask

	// Words offered in idle cycles and a non-compare opcode are ignored
	task automatic t_refused();
		bank_sel = 4'h2;
		run_cmp(OPC_EQUAL, 1'b1, 8'h44, 8'h09, 8'h09, 1'b1, 1'b1);
		@(posedge mclk_i);
		while (phase_o !== PH_Q4) @(posedge mclk_i);
		instr_valid_i <= 1'b1;
		instr_word_i  <= 16'h0510;
		@(posedge mclk_i);
		check(instr_accept_o, 1'b0);
		instr_valid_i <= 1'b0;
		@(posedge mclk_i);
		check(file_rd_o, 1'b0);
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		check(phase_o, PH_Q1);
		check({skip_o, discard_o, done_o, file_rd_o}, 4'h0);
		t_greater();
		t_less();
		t_equal();
		t_bank();
		t_two_word();
		t_refused();
		conclude();
	end

	// Eighteen instructions of at most twelve clocks fit well inside this span
	initial begin
		#100000;
		mismatches++;
		conclude();
	end

endmodule // tb_compare_skip_instr_exec
